// File: cil_io_line_ctrl.sv
// Camera I/O line control: three external lines, output multiplexers, pulse generator
// and the rear status lamp, configured over APB.
// Assumes camera timing inputs synchronous to pclk; pad logic joins out/oe/in per line.
//
// The implementer's own choices: the APB register port and the placing of the registers.
module cil_io_line_ctrl
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cil_pkg::cil_cam_sig_t cam_sig,
    input wire logic unit_ready,
    input wire logic usb_slow_link,
    input wire logic [2:0] line_in,
    output logic [2:0] line_out,
    output logic [2:0] line_oe,
    output logic status_lamp
);
    import cil_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [21:0] clamp_us(input logic [21:0] v, input logic [21:0] lo,
                                             input logic [21:0] hi);
        clamp_us = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic line_can_drive(input logic [1:0] idx);
        line_can_drive = (idx == 2'd1) || (idx == 2'd2);
    endfunction

    // ==========================================================
    // APB slave and register state
    logic [1:0] sel_q, sel_d;
    logic [2:0] user_q, user_d;
    logic [21:0] period_q, period_d;
    logic [21:0] high_q, high_d;
    logic lamp_en_q, lamp_en_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic cfg_wr;
    cil_line_cfg_t cfg_wdata;
    cil_line_cfg_t cfg_sel;
    cil_line_cfg_t cfg_all [3];
    logic [2:0] in_level_q, in_level_d;

    logic setup;
    logic write_now;
    logic mapped;

    // Read data is captured at the setup edge so it stands with pready in the access cycle
    assign setup = psel && !penable;
    assign write_now = psel && penable && pready_q && pwrite;

    always_comb
    begin
        case (paddr)
            CIL_SELECT_OFS, CIL_LINE_CFG_OFS, CIL_LINE_STATUS_OFS, CIL_USER_LEVEL_OFS,
            CIL_PULSE_PERIOD_OFS, CIL_PULSE_HIGH_OFS, CIL_LAMP_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign cfg_wr = clk_en && write_now && mapped && (paddr == CIL_LINE_CFG_OFS);
    assign cfg_wdata = '{direction: pwdata[CIL_CFG_DIR_BIT],
                         polarity: pwdata[CIL_CFG_POL_BIT],
                         source: cil_src_t'(pwdata[CIL_CFG_SRC_LSB +: CIL_SRC_W])};

    cil_line_cfg_mem u_cfg
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(cfg_wr),
        .wr_addr(sel_q),
        .wr_data(cfg_wdata),
        .rd_addr(sel_d), // Next select: the registered read already follows a fresh select
        .rd_data(cfg_sel),
        .cfg_all(cfg_all)
    );

    always_comb
    begin
        sel_d = sel_q;
        user_d = user_q;
        period_d = period_q;
        high_d = high_q;
        lamp_en_d = lamp_en_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (setup)
        begin
            pready_d = 1'b1;
            pslverr_d = !mapped;
        end
        if (write_now && mapped)
        begin
            case (paddr)
                CIL_SELECT_OFS:
                    if (pwdata[1:0] < CIL_LINE_COUNT)
                        sel_d = pwdata[1:0];
                CIL_USER_LEVEL_OFS: user_d = pwdata[2:0];
                CIL_PULSE_PERIOD_OFS:
                    period_d = clamp_us(pwdata[21:0], CIL_PERIOD_MIN_US,
                                        CIL_PERIOD_MAX_US);
                CIL_PULSE_HIGH_OFS:
                    high_d = clamp_us(pwdata[21:0], CIL_HIGH_MIN_US, CIL_HIGH_MAX_US);
                CIL_LAMP_OFS: lamp_en_d = pwdata[0];
                default: ;
            endcase
        end
        if (setup && !pwrite)
        begin
            case (paddr)
                CIL_SELECT_OFS: prdata_d = {30'h0, sel_q};
                CIL_LINE_CFG_OFS:
                    prdata_d = {24'h0, cfg_sel.source, 2'h0, cfg_sel.polarity,
                                cfg_sel.direction};
                CIL_LINE_STATUS_OFS: prdata_d = {31'h0, in_level_q[sel_q]};
                CIL_USER_LEVEL_OFS: prdata_d = {29'h0, user_q};
                CIL_PULSE_PERIOD_OFS: prdata_d = {10'h0, period_q};
                CIL_PULSE_HIGH_OFS: prdata_d = {10'h0, high_q};
                CIL_LAMP_OFS: prdata_d = {31'h0, lamp_en_q};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q <= 2'h0;
            user_q <= 3'h0;
            period_q <= CIL_PERIOD_RESET_US;
            high_q <= CIL_HIGH_RESET_US;
            lamp_en_q <= CIL_LAMP_RESET;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_q <= sel_d;
            user_q <= user_d;
            period_q <= period_d;
            high_q <= high_d;
            lamp_en_q <= lamp_en_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==========================================================
    // Input level capture: only lines 1 and 2 have receivers
    always_comb
    begin
        in_level_d = 3'h0;
        in_level_d[0] = line_in[0];
        in_level_d[1] = line_in[1];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_level_q <= 3'h0;
        else if (clk_en)
            in_level_q <= in_level_d;
    end

    // ==========================================================
    // Sensor readout window
    typedef enum logic {CIL_RD_IDLE, CIL_RD_ACTIVE} cil_rd_state_t;
    cil_rd_state_t rd_st_q, rd_st_d;
    logic exposure_prev_q, exposure_prev_d;

    always_comb
    begin
        rd_st_d = rd_st_q;
        exposure_prev_d = cam_sig.exposure;
        case (rd_st_q)
            // Rise on exposure end, ahead of black rows and pixel output
            CIL_RD_IDLE:
                if ((exposure_prev_q && !cam_sig.exposure) || cam_sig.readout_start)
                    rd_st_d = CIL_RD_ACTIVE;
            CIL_RD_ACTIVE:
                if (cam_sig.frame_out_done)
                    rd_st_d = CIL_RD_IDLE;
            default: rd_st_d = CIL_RD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_st_q <= CIL_RD_IDLE;
            exposure_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_st_q <= rd_st_d;
            exposure_prev_q <= exposure_prev_d;
        end
    end

    // ==========================================================
    // Pulse generator: microsecond tick, then a period counter compared against the high time
    logic [7:0] us_cnt_q, us_cnt_d;
    logic [21:0] pg_cnt_q, pg_cnt_d;
    logic pulse_q, pulse_d;
    logic us_tick;

    assign us_tick = (us_cnt_q == CIL_US_CYCLES - 8'h1);

    always_comb
    begin
        us_cnt_d = us_tick ? 8'h0 : us_cnt_q + 8'h1;
        pg_cnt_d = pg_cnt_q;
        if (us_tick)
            pg_cnt_d = (pg_cnt_q >= period_q - 22'h1) ? 22'h0 : pg_cnt_q + 22'h1;
        // High phase leads each period; saturates high when high time covers it
        pulse_d = (high_q >= period_q) || (pg_cnt_d < high_q);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            us_cnt_q <= 8'h0;
            pg_cnt_q <= 22'h0;
            pulse_q <= 1'b1;
        end
        else if (clk_en)
        begin
            us_cnt_q <= us_cnt_d;
            pg_cnt_q <= pg_cnt_d;
            pulse_q <= pulse_d;
        end
    end

    // ==========================================================
    // Output multiplexers and pad drive
    logic [2:0] out_d, out_q;
    logic [2:0] oe_d, oe_q;

    always_comb
    begin
        logic src;
        src = 1'b0;
        out_d = 3'h0;
        oe_d = 3'h0;
        for (int i = 0; i < 3; i++)
        begin
            case (cfg_all[i].source)
                CIL_SRC_TRIGGER: src = cam_sig.trigger;
                CIL_SRC_EXPOSURE: src = cam_sig.exposure;
                CIL_SRC_STROBE: src = cam_sig.strobe;
                CIL_SRC_READOUT: src = (rd_st_q == CIL_RD_ACTIVE);
                CIL_SRC_USER_A: src = user_q[0];
                CIL_SRC_USER_B: src = user_q[1];
                CIL_SRC_USER_C: src = user_q[2];
                CIL_SRC_HIGH: src = 1'b1;
                CIL_SRC_LOW: src = 1'b0;
                CIL_SRC_PULSE: src = pulse_q;
                default: src = 1'b0;
            endcase
            // Line 1 has no driver, so even readout cannot reach it
            oe_d[i] = line_can_drive(2'(i))
                      && (cfg_all[i].direction == CIL_DIR_OUTPUT);
            out_d[i] = oe_d[i] && (src ^ cfg_all[i].polarity);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= 3'h0;
            oe_q <= 3'h0;
        end
        else if (clk_en)
        begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    // ==========================================================
    // Status lamp
    logic [25:0] blink_cnt_q, blink_cnt_d;
    logic blink_q, blink_d;
    logic lamp_q, lamp_d;

    always_comb
    begin
        blink_cnt_d = blink_cnt_q + 26'h1;
        blink_d = blink_q;
        if (blink_cnt_q == CIL_BLINK_CYCLES - 26'h1)
        begin
            blink_cnt_d = 26'h0;
            blink_d = !blink_q;
        end
        lamp_d = 1'b0;
        if (lamp_en_q && unit_ready)
            lamp_d = usb_slow_link ? blink_q : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blink_cnt_q <= 26'h0;
            blink_q <= 1'b0;
            lamp_q <= 1'b0;
        end
        else if (clk_en)
        begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
            lamp_q <= lamp_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign line_out = out_q;
    assign line_oe = oe_q;
    assign status_lamp = lamp_q;
endmodule

// File: cil_pkg.sv
// Package for the camera I/O line control block: register map, field codes, timing.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
package cil_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] CIL_SELECT_OFS = 12'h000;
    localparam logic [11:0] CIL_LINE_CFG_OFS = 12'h004;
    localparam logic [11:0] CIL_LINE_STATUS_OFS = 12'h008;
    localparam logic [11:0] CIL_USER_LEVEL_OFS = 12'h00C;
    localparam logic [11:0] CIL_PULSE_PERIOD_OFS = 12'h010;
    localparam logic [11:0] CIL_PULSE_HIGH_OFS = 12'h014;
    localparam logic [11:0] CIL_LAMP_OFS = 12'h018;

    // ==========================================================
    // Field positions within the line configuration word
    localparam int CIL_CFG_DIR_BIT = 0;
    localparam int CIL_CFG_POL_BIT = 1;
    localparam int CIL_CFG_SRC_LSB = 4;
    localparam int CIL_SRC_W = 4;

    // ==========================================================
    // Codes and reset values
    localparam logic [1:0] CIL_LINE_COUNT = 2'h3;
    localparam logic CIL_DIR_INPUT = 1'b0;
    localparam logic CIL_DIR_OUTPUT = 1'b1;
    localparam logic CIL_POL_RESET = 1'b1;
    localparam logic CIL_LAMP_RESET = 1'b1;
    localparam logic [3:0] CIL_SRC_RESET = 4'h8;

    typedef enum logic [3:0] {
        CIL_SRC_TRIGGER = 4'h0,
        CIL_SRC_EXPOSURE = 4'h1,
        CIL_SRC_STROBE = 4'h2,
        CIL_SRC_READOUT = 4'h3,
        CIL_SRC_USER_A = 4'h4,
        CIL_SRC_USER_B = 4'h5,
        CIL_SRC_USER_C = 4'h6,
        CIL_SRC_HIGH = 4'h7,
        CIL_SRC_LOW = 4'h8,
        CIL_SRC_PULSE = 4'h9
    } cil_src_t;

    // ==========================================================
    // Timing: pulse generator counts in microseconds
    localparam int CIL_CLK_MHZ = 200;
    localparam logic [7:0] CIL_US_CYCLES = 8'(CIL_CLK_MHZ);
    localparam logic [21:0] CIL_PERIOD_MIN_US = 22'd10;
    localparam logic [21:0] CIL_PERIOD_MAX_US = 22'd2000000;
    localparam logic [21:0] CIL_PERIOD_RESET_US = 22'd1000000;
    localparam logic [21:0] CIL_HIGH_MIN_US = 22'd1;
    localparam logic [21:0] CIL_HIGH_MAX_US = 22'd2000000;
    localparam logic [21:0] CIL_HIGH_RESET_US = 22'd500000;
    // Status lamp blink half period in ms when on a slow link
    localparam int CIL_BLINK_MS = 250;
    localparam logic [25:0] CIL_BLINK_CYCLES = 26'(CIL_BLINK_MS * CIL_CLK_MHZ * 1000);

    // Per-line settings carried as one group
    typedef struct packed {
        logic direction;
        logic polarity;
        cil_src_t source;
    } cil_line_cfg_t;

    // Camera timing sources feeding the output multiplexers
    typedef struct packed {
        logic trigger;
        logic exposure;
        logic strobe;
        logic readout_start;
        logic frame_out_done;
    } cil_cam_sig_t;

endpackage

// File: cil_line_cfg_mem.sv
// Small per-line configuration store, three words, registered read port.
// Assumes one writer and reset values from cil_pkg.
module cil_line_cfg_mem
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire cil_pkg::cil_line_cfg_t wr_data,
    input wire logic [1:0] rd_addr,
    output cil_pkg::cil_line_cfg_t rd_data,
    output cil_pkg::cil_line_cfg_t cfg_all [3]
);
    import cil_pkg::*;

    cil_line_cfg_t mem_q [3];
    cil_line_cfg_t mem_d [3];
    cil_line_cfg_t rd_q;
    cil_line_cfg_t rd_d;

    always_comb
    begin
        mem_d = mem_q;
        rd_d = rd_q;
        if (clk_en)
        begin
            if (wr_en && wr_addr < CIL_LINE_COUNT)
                mem_d[wr_addr] = wr_data;
            rd_d = (rd_addr < CIL_LINE_COUNT) ? mem_d[rd_addr] : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                mem_q[i] <= '{direction: CIL_DIR_INPUT, polarity: CIL_POL_RESET,
                              source: cil_src_t'(CIL_SRC_RESET)};
            rd_q <= '{direction: CIL_DIR_INPUT, polarity: CIL_POL_RESET,
                      source: cil_src_t'(CIL_SRC_RESET)};
        end
        else
        begin
            mem_q <= mem_d;
            rd_q <= rd_d;
        end
    end

    assign rd_data = rd_q;
    assign cfg_all = mem_q;
endmodule

// File: cil_io_line_ctrl_asserts.sv
// Port-level checker for the camera I/O line control block.
// Assumes one pclk domain; bound to every instance of the top module.
module cil_io_asserts
    import cil_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic unit_ready,
    input wire logic usb_slow_link,
    input wire logic [2:0] line_out,
    input wire logic [2:0] line_oe,
    input wire logic status_lamp
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Bus answer
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_quiet;
        !psel && !$past(psel) && clk_en;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready && clk_en |=> !pready)
        else $error("answer longer than one cycle");
    a_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without answer");
    a_err_on_unmapped: assert property (s_setup ##0 paddr[1:0] == 2'h0
        |=> pslverr == ($past(paddr) > 12'h018))
        else $error("error flag wrong for address");

    // ==========================================================
    // Lines and lamp
    a_line1_no_drive: assert property (!line_oe[0])
        else $error("first line driven");
    a_input_undriven: assert property ((line_out & ~line_oe) == 3'h0)
        else $error("level on undriven line");
    a_lamp_off_unready: assert property (!unit_ready && clk_en |=> !status_lamp)
        else $error("lamp lit while not ready");
    a_lamp_steady_on: assert property (status_lamp && unit_ready && !usb_slow_link
        ##0 s_quiet |=> status_lamp)
        else $error("steady lamp dropped");
endmodule

bind cil_io_line_ctrl cil_io_asserts cil_io_asserts_inst (.pclk, .presetn, .clk_en, .psel,
    .penable, .paddr, .pready, .pslverr, .unit_ready, .usb_slow_link, .line_out, .line_oe,
    .status_lamp);

// File: cil_ext_equip.sv
// External equipment on the three connector lines.
// Assumes a pull-up on each line; drives only where ext_en is set.
module cil_ext_equip
(
    input wire logic [2:0] line_oe,
    input wire logic [2:0] line_out,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line takes ext_val where ext_en is set, else floats to the pull-up; never keeps the old level
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            line_in[i] = line_oe[i] ? line_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
endmodule

// File: test_camera_io_line_control.sv
// Self-checking bench for the camera I/O line control block.
// Assumes the checker is bound and equipment sits on the lines.
module test_camera_io_line_control;
    timeunit 1ns;
    timeprecision 1ps;
    import cil_pkg::*;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cil_cam_sig_t cam_sig = '0;
    logic unit_ready = 1'b1;
    logic usb_slow_link = 1'b0;
    logic [2:0] ext_en = 3'h3;
    logic [2:0] ext_val = 3'h1;
    logic [2:0] line_in;
    logic [2:0] line_out;
    logic [2:0] line_oe;
    logic status_lamp;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int check_count = 0;
    int hi;
    // Rows: source, polarity, expected level
    logic [5:0] rows [12] = '{6'h01, 6'h02, 6'h04, 6'h09, 6'h11, 6'h14, 6'h17, 6'h19,
        6'h1D, 6'h1E, 6'h20, 6'h23};

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    cil_io_line_ctrl cil_io_line_ctrl_inst (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cam_sig, .unit_ready,
        .usb_slow_link, .line_in, .line_out, .line_oe, .status_lamp);
    cil_ext_equip cil_ext_equip_inst (.line_oe, .line_out, .ext_en, .ext_val, .line_in);

    // ==========================================================
    // Tasks
    task complete_run();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One edge first, so a released strobe is never raised in the same step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            num_errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    task settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task count_high(input int n);
        hi = 0;
        repeat (n)
        begin
            @(posedge pclk);
            hi += int'(line_out[2]);
        end
    endtask

    task do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        settle(16);
        `CHK({line_oe, line_out, pready, status_lamp}, 8'h00)
        @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        rdchk(CIL_LINE_CFG_OFS, 32'h00000082);
        rdchk(CIL_PULSE_PERIOD_OFS, 32'h000F4240);
        rdchk(CIL_PULSE_HIGH_OFS, 32'h0007A120);
        rdchk(CIL_LAMP_OFS, 32'h00000001);
        `CHK(status_lamp, 1'b1)
        $display("test reset values done");
        wr(CIL_PULSE_PERIOD_OFS, 32'h00000005);
        rdchk(CIL_PULSE_PERIOD_OFS, 32'h0000000A);
        wr(CIL_PULSE_HIGH_OFS, 32'h00000001);
        wr(CIL_SELECT_OFS, 32'h00000002);
        wr(CIL_LINE_CFG_OFS, 32'h00000091);
        settle(2200);
        `CHK(line_oe[2], 1'b1)
        count_high(2000);
        `CHK(hi, 200)
        wr(CIL_PULSE_HIGH_OFS, 32'h000007D0);
        settle(5);
        count_high(2000);
        `CHK(hi, 2000)
        $display("test pulse done");
        cam_sig.trigger <= 1'b1;
        cam_sig.strobe <= 1'b1;
        wr(CIL_USER_LEVEL_OFS, 32'h00000005);
        wr(CIL_SELECT_OFS, 32'h00000001);
        foreach (rows[i])
        begin
            wr(CIL_LINE_CFG_OFS, 32'({rows[i][5:2], 2'h0, rows[i][1], 1'b1}));
            settle(3);
            `CHK({line_oe[1], line_out[1]}, {1'b1, rows[i][0]})
        end
        $display("test source table done");
        wr(CIL_LINE_CFG_OFS, 32'h00000070);
        settle(3);
        `CHK(line_oe[1], 1'b0)
        rdchk(CIL_LINE_STATUS_OFS, 32'h00000000);
        wr(CIL_SELECT_OFS, 32'h00000000);
        rdchk(CIL_LINE_STATUS_OFS, 32'h00000001);
        ext_val <= 3'h0;
        settle(3);
        rdchk(CIL_LINE_STATUS_OFS, 32'h00000000);
        wr(CIL_SELECT_OFS, 32'h00000003);
        rdchk(CIL_SELECT_OFS, 32'h00000000);
        wr(CIL_LINE_CFG_OFS, 32'h00000071);
        settle(3);
        `CHK(line_oe[0], 1'b0)
        $display("test lines done");
        wr(CIL_SELECT_OFS, 32'h00000001);
        wr(CIL_LINE_CFG_OFS, 32'h00000031);
        cam_sig.exposure <= 1'b1;
        settle(5);
        `CHK(line_out[1], 1'b0)
        @(posedge pclk);
        cam_sig.exposure <= 1'b0;
        settle(4);
        `CHK(line_out[1], 1'b1)
        settle(20);
        `CHK(line_out[1], 1'b1)
        @(posedge pclk);
        cam_sig.frame_out_done <= 1'b1;
        @(posedge pclk);
        cam_sig.frame_out_done <= 1'b0;
        settle(4);
        `CHK(line_out[1], 1'b0)
        @(posedge pclk);
        cam_sig.readout_start <= 1'b1;
        @(posedge pclk);
        cam_sig.readout_start <= 1'b0;
        settle(4);
        `CHK(line_out[1], 1'b1)
        $display("test readout done");
        apb(1'b0, 12'h020, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        wr(CIL_LAMP_OFS, 32'h00000000);
        settle(2);
        `CHK(status_lamp, 1'b0)
        wr(CIL_LAMP_OFS, 32'h00000001);
        settle(2);
        `CHK(status_lamp, 1'b1)
        @(posedge pclk);
        unit_ready <= 1'b0;
        settle(2);
        `CHK(status_lamp, 1'b0)
        @(posedge pclk);
        unit_ready <= 1'b1;
        usb_slow_link <= 1'b1;
        settle(2);
        `CHK(status_lamp, 1'b0)
        @(posedge pclk);
        usb_slow_link <= 1'b0;
        clk_en <= 1'b0;
        settle(3);
        `CHK(status_lamp, 1'b0)
        @(posedge pclk);
        clk_en <= 1'b1;
        settle(2);
        `CHK(status_lamp, 1'b1)
        $display("test bus and lamp done");
        do_reset();
        rdchk(CIL_LINE_CFG_OFS, 32'h00000082);
        $display("test second reset done");
        complete_run();
    end
endmodule
